/* File: rtl/deerp_pkg.sv */
// deerp_pkg: constants and carrier types for the data eeprom row programmer
// assumes a 10 MHz core clock and an 8-bit eeprom behind a 32-bit apb slave
package deerp_pkg;

  // apb map: control register at its printed byte offset, eeprom window above
  localparam logic [15:0] DEERP_CTRL_ADDR    = 16'h0030;
  localparam logic [15:0] DEERP_ARRAY_BASE   = 16'h1000;
  localparam int          DEERP_ARRAY_BYTES  = 256;
  localparam int          DEERP_ROW_BYTES    = 32;
  localparam int          DEERP_COL_BITS     = 5;
  localparam int          DEERP_ADDR_BITS    = 8;

  // control register fields
  localparam int          DEERP_PGM_BIT      = 0;
  localparam int          DEERP_LAT_BIT      = 1;
  localparam logic [7:0]  DEERP_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  DEERP_ERASED_BYTE  = 8'hff;

  // programming cycle length
  localparam int          DEERP_CLK_HZ       = 10_000_000;
  localparam int          DEERP_PROG_US      = 100;
  localparam int          DEERP_PROG_CYCLES  = (DEERP_PROG_US * (DEERP_CLK_HZ / 1_000_000));

  typedef enum {
    DEERP_IDLE,
    DEERP_PROG
  } deerp_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } deerp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } deerp_apb_rsp_t;

endpackage

/* File: rtl/deerp_cells.sv */
// deerp_cells: the eeprom cell array with one read port and a row program port
// assumes the caller presents a whole row with a per-byte write mask
`timescale 1ns/100ps
`default_nettype none
module deerp_cells
  import deerp_pkg::*;
#(
  parameter int ROWS = DEERP_ARRAY_BYTES / DEERP_ROW_BYTES,
  parameter int RB   = DEERP_ROW_BYTES
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [DEERP_ADDR_BITS-1:0] rd_addr,
  output logic      [7:0]                 rd_data,
  input  wire logic                       prog_en,
  input  wire logic [$clog2(ROWS)-1:0]    prog_row,
  input  wire logic [RB-1:0]              prog_mask,
  input  wire logic [RB*8-1:0]            prog_data
);

  logic [7:0] cell_mem [ROWS*RB];
  integer     i;

  // cells are nonvolatile: reset does not erase them
  always_ff @(posedge clk) begin
    if (nrst && prog_en) begin
      for (i = 0; i < RB; i = i + 1) begin
        if (prog_mask[i]) begin
          cell_mem[{prog_row, i[DEERP_COL_BITS-1:0]}] <= prog_data[i*8 +: 8];
        end
      end
    end
  end

  assign rd_data = cell_mem[rd_addr];

endmodule
`default_nettype wire

/* File: rtl/deerp_top.sv */
// deerp_top: data eeprom access control with 32 byte write latches
// assumes an apb master (cpu side); fetch port reads eeprom as plain rom
`timescale 1ns/100ps
`default_nettype none
module deerp_top
  import deerp_pkg::*;
#(
  parameter int PROG_CYCLES = DEERP_PROG_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire deerp_apb_req_t             apb_req,
  output deerp_apb_rsp_t                  apb_rsp,
  input  wire logic                       fetch_req,
  input  wire logic [DEERP_ADDR_BITS-1:0] fetch_addr,
  output logic      [7:0]                 fetch_data,
  output logic                            fetch_valid,
  output logic                            prog_busy
);

  localparam int ROWS     = DEERP_ARRAY_BYTES / DEERP_ROW_BYTES;
  localparam int ROW_BITS = $clog2(ROWS);
  localparam int CNT_W    = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    deerp_state_t                 state;
    logic                         lat;
    logic                         program_trigger_bit;
    logic [DEERP_ROW_BYTES-1:0]   lmask;
    logic [DEERP_ROW_BYTES*8-1:0] ldata;
    logic [ROW_BITS-1:0]          row;
    logic [CNT_W-1:0]             cnt;
    logic                         prog_en;
    deerp_apb_rsp_t               rsp;
    logic [7:0]                   fdata;
    logic                         fvalid;
  } deerp_regs_t;

  deerp_regs_t s_reg;
  deerp_regs_t s_next;

  logic [7:0]                 cell_rd;
  logic [7:0]                 fetch_rd;
  logic [DEERP_ADDR_BITS-1:0] arr_off;

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= DEERP_ARRAY_BASE) &&
               (a < DEERP_ARRAY_BASE + 16'(DEERP_ARRAY_BYTES));
  endfunction

  function automatic logic [DEERP_ADDR_BITS-1:0] arr_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - DEERP_ARRAY_BASE;
    arr_index = d[DEERP_ADDR_BITS-1:0];
  endfunction

  assign arr_off = arr_index(apb_req.paddr);

  deerp_cells u_cells (
    .clk       (clk),
    .nrst      (nrst),
    .rd_addr   (arr_off),
    .rd_data   (cell_rd),
    .prog_en   (s_reg.prog_en),
    .prog_row  (s_reg.row),
    .prog_mask (s_reg.lmask),
    .prog_data (s_reg.ldata)
  );

  // second read port for instruction fetch
  deerp_cells u_fetch_shadow (
    .clk       (clk),
    .nrst      (nrst),
    .rd_addr   (fetch_addr),
    .rd_data   (fetch_rd),
    .prog_en   (s_reg.prog_en),
    .prog_row  (s_reg.row),
    .prog_mask (s_reg.lmask),
    .prog_data (s_reg.ldata)
  );

  always_comb begin
    logic access;
    logic [DEERP_COL_BITS-1:0] col;
    logic [7:0] wbyte;
    access = 1'b0;
    col    = '0;
    wbyte  = '0;
    s_next = s_reg;
    s_next.prog_en     = 1'b0;
    s_next.rsp.pready  = 1'b0;
    s_next.rsp.pslverr = 1'b0;
    s_next.fvalid      = 1'b0;
    access = apb_req.psel && apb_req.penable && !s_reg.rsp.pready;
    col    = arr_off[DEERP_COL_BITS-1:0];
    wbyte  = apb_req.pwdata[7:0];

    if (fetch_req) begin
      s_next.fdata  = fetch_rd;
      s_next.fvalid = 1'b1;
    end

    if (access) begin
      s_next.rsp.pready = 1'b1;
      s_next.rsp.prdata = '0;
      if (apb_req.paddr == DEERP_CTRL_ADDR) begin
        if (apb_req.pwrite) begin
          if (s_reg.state == DEERP_IDLE) begin
            s_next.lat = apb_req.pwdata[DEERP_LAT_BIT];
            s_next.program_trigger_bit = apb_req.pwdata[DEERP_PGM_BIT] && apb_req.pwdata[DEERP_LAT_BIT];
            if (s_reg.lat && !apb_req.pwdata[DEERP_LAT_BIT]) begin
              s_next.lmask = '0;
              s_next.ldata = '0;
            end
            if (s_next.program_trigger_bit) begin
              s_next.state = DEERP_PROG;
              s_next.cnt   = CNT_W'(PROG_CYCLES);
            end
          end
        end else begin
          s_next.rsp.prdata[DEERP_LAT_BIT] = s_reg.lat;
          s_next.rsp.prdata[DEERP_PGM_BIT] = s_reg.program_trigger_bit;
        end
      end else if (in_array(apb_req.paddr)) begin
        if (apb_req.pwrite) begin
          if (s_reg.lat && s_reg.state == DEERP_IDLE) begin
            s_next.ldata[col*8 +: 8] = s_reg.lmask[col] ?
                                       (s_reg.ldata[col*8 +: 8] & wbyte) : wbyte;
            s_next.lmask[col] = 1'b1;
            s_next.row = arr_off[DEERP_ADDR_BITS-1:DEERP_COL_BITS];
          end
        end else begin
          s_next.rsp.prdata[7:0] = cell_rd;
        end
      end else begin
        s_next.rsp.pslverr = 1'b1;
      end
    end

    if (s_reg.state == DEERP_PROG) begin
      if (s_reg.cnt == CNT_W'(1)) begin
        s_next.prog_en = 1'b1;
        s_next.state   = DEERP_IDLE;
      end else begin
        s_next.cnt = s_reg.cnt - CNT_W'(1);
      end
    end
    // on the same edge as the row write lands: end of cycle
    if (s_reg.prog_en) begin
      s_next.lat   = 1'b0;
      s_next.program_trigger_bit   = 1'b0;
      s_next.lmask = '0;
      s_next.ldata = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg       <= '0;
      s_reg.state <= DEERP_IDLE;
      s_reg.lat   <= DEERP_CTRL_RESET[DEERP_LAT_BIT];
      s_reg.program_trigger_bit   <= DEERP_CTRL_RESET[DEERP_PGM_BIT];
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp     = s_reg.rsp;
  assign fetch_data  = s_reg.fdata;
  assign fetch_valid = s_reg.fvalid;
  assign prog_busy   = s_reg.program_trigger_bit;

endmodule
`default_nettype wire

/* File: testbench/deerp_top_properties.sv */
// deerp_chk: port checks for deerp_top
// assumes binding into deerp_top with its PROG_CYCLES
`timescale 1ns/100ps
`default_nettype none
module deerp_chk
  import deerp_pkg::*;
#(
  parameter int PROG_CYCLES = 8
) (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire deerp_apb_req_t             apb_req,
  input wire deerp_apb_rsp_t             apb_rsp,
  input wire logic                       fetch_req,
  input wire logic [DEERP_ADDR_BITS-1:0] fetch_addr,
  input wire logic [7:0]                 fetch_data,
  input wire logic                       fetch_valid,
  input wire logic                       prog_busy
);
  wire logic ctl = apb_req.paddr == DEERP_CTRL_ADDR;
  wire logic win = apb_req.paddr[15:8] == 8'h10;
  wire logic rd  = apb_rsp.pready && !apb_req.pwrite;
  logic [15:0] cnt_reg;
  // busy length counter, zero outside cycles
  always_ff @(posedge clk) begin
    cnt_reg <= (!nrst || !prog_busy) ? 16'h0000 : cnt_reg + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  fetch_ans_a: assert property (fetch_req |=> fetch_valid)
    else $error("fetch not answered");
  fetch_idle_a: assert property (!fetch_req |=> !fetch_valid)
    else $error("spurious fetch valid");
  rdy_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  ctrl_zero_a: assert property (rd && ctl |-> apb_rsp.prdata[31:2] == 30'h0)
    else $error("control upper bits not zero");
  unmap_err_a: assert property (apb_rsp.pready && !ctl && !win |-> apb_rsp.pslverr)
    else $error("unmapped access without error");
  map_ok_a: assert property (apb_rsp.pready && (ctl || win) |-> !apb_rsp.pslverr)
    else $error("mapped access flagged");
  busy_hold_a: assert property (prog_busy && cnt_reg < PROG_CYCLES - 1 |=> prog_busy)
    else $error("programming ended early");
  busy_end_a: assert property (cnt_reg <= PROG_CYCLES + 2)
    else $error("programming never ends");
endmodule
bind deerp_top deerp_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
  .clk(clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
  .fetch_valid(fetch_valid), .prog_busy(prog_busy)
);
`default_nettype wire

/* File: testbench/deerp_cpu.sv */
// deerp_cpu: apb master standing in for the cpu core
// assumes the bench calls xfer; rsp comes from deerp_top
`timescale 1ns/100ps
`default_nettype none
module deerp_cpu
  import deerp_pkg::*;
(
  input  wire logic           clk,
  output deerp_apb_req_t      req,
  input  wire deerp_apb_rsp_t rsp
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    // released lines show inverse, not old value
    req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask
endmodule
`default_nettype wire

/* File: testbench/data_eeprom_row_programmer_bench.sv */
// bench: row programming, read back, fetch
// assumes deerp_top with short programming count
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_row_programmer_bench;
  import deerp_pkg::*;
  localparam logic [15:0] CTL = DEERP_CTRL_ADDR;
  localparam logic [15:0] ROW = DEERP_ARRAY_BASE + 16'h0020;
  logic clk = 1'b0, nrst = 1'b0, fetch_req = 1'b0, fetch_valid, prog_busy;
  logic [7:0] fetch_addr = 8'h00, fetch_data;
  deerp_apb_req_t req;
  deerp_apb_rsp_t rsp;
  logic [8:0] q[$], fq[$];
  logic [7:0] d[32];
  int mismatches = 0, n_compared = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  deerp_top #(.PROG_CYCLES(8)) dut (.clk(clk), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_data(fetch_data), .fetch_valid(fetch_valid), .prog_busy(prog_busy));
  deerp_cpu cpu (.clk(clk), .req(req), .rsp(rsp));
  task cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    cpu.xfer(1'b1, a, {24'h0000_00, v});
  endtask
  task rd(input logic [15:0] a, input logic [8:0] e);
    q.push_back(e);
    cpu.xfer(1'b0, a, 32'h0000_0000);
  endtask
  // one edge for busy to rise, then bounded wait
  task idle;
    @(posedge clk);
    for (int n = 0; n < 40 && prog_busy !== 1'b0; n++) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && q.size() > 0)
      cmp({rsp.pslverr, rsp.prdata[7:0]}, q.pop_front());
    if (fetch_valid === 1'b1 && fq.size() > 0) cmp({1'b0, fetch_data}, fq.pop_front());
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    void'($urandom(32'h18a7));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(CTL, 9'h000);
    wr(16'h0034, 8'h03);
    rd(16'h0034, 9'h100);
    wr(CTL, 8'h01);
    rd(CTL, 9'h000);
    wr(CTL, 8'h02);
    rd(CTL, 9'h002);
    foreach (d[i]) begin
      d[i] = 8'($urandom);
      wr(ROW + 16'(i), d[i]);
    end
    wr(ROW + 16'h0003, 8'h5a);
    d[3] &= 8'h5a;
    wr(CTL, 8'h03);
    idle;
    rd(CTL, 9'h000);
    foreach (d[i]) rd(ROW + 16'(i), {1'b0, d[i]});
    foreach (d[i]) begin
      @(posedge clk);
      fetch_req <= 1'b1;
      fetch_addr <= 8'h20 + 8'(i);
      fq.push_back({1'b0, d[i]});
    end
    @(posedge clk);
    fetch_req <= 1'b0;
    wr(CTL, 8'h02);
    wr(ROW + 16'h0005, ~d[5]);
    rd(ROW + 16'h0005, {1'b0, d[5]});
    wr(CTL, 8'h00);
    wr(CTL, 8'h02);
    wr(CTL, 8'h03);
    idle;
    rd(ROW + 16'h0005, {1'b0, d[5]});
    wr(ROW + 16'h0006, 8'h00);
    rd(ROW + 16'h0006, {1'b0, d[6]});
    test_done;
  end
endmodule
`default_nettype wire
